/* pkg/vrc_pkg.sv */
// Constants for the channel-0 resource control and status registers
// Notes on behaviour
// RULE1: Traffic-class map has one bit per class; bit 0 fixed, bits 1-7 writable, reset all ones.
// RULE2: Writing one to table-load copies the stored arbitration table into the arbiter.
// RULE3: Writing zero to table-load does nothing; the bit always reads zero.
// RULE4: A table-load acts only when the selected arbitration scheme uses the table.
// RULE5: Software selects only schemes whose capability bit is set.
// RULE6: Channel identifier is read-only and fixed at zero.
// RULE7: Channel enable is read-only and always one.
// RULE8: Table status sets on any table entry write, clears when a load completes.
// RULE9: Table status is meaningful only while the selected scheme uses the table.
// RULE10: Negotiation-pending always reads zero for this channel.
// RULE11: A side-band reader must not trust negotiation-pending for negotiation state.
// RULE12: Reserved bits read zero and ignore writes.
package vrc_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam logic [11:0] VC0_CTL_OFFSET    = 12'h214;
  localparam logic [11:0] VC0_STS_OFFSET    = 12'h218;
  // Control register fields
  localparam int          TC_MAP_LSB        = 0;
  localparam int          TC_MAP_W          = 8;
  localparam logic [7:0]  TC_MAP_RESET      = 8'hFF;
  localparam logic [7:0]  TC_MAP_WR_MASK    = 8'hFE;
  localparam int          TABLE_LOAD_BIT    = 16;
  localparam int          SCHEME_LSB        = 17;
  localparam int          SCHEME_W          = 3;
  localparam logic [2:0]  SCHEME_RESET      = 3'h0;
  localparam int          CHAN_ID_LSB       = 24;
  localparam logic [2:0]  CHAN_ID_VALUE     = 3'h0;
  localparam int          CHAN_EN_BIT       = 31;
  localparam logic        CHAN_EN_VALUE     = 1'b1;
  // Status register fields
  localparam int          TABLE_STATUS_BIT  = 16;
  localparam int          NEG_PENDING_BIT   = 17;
  localparam logic        NEG_PENDING_VALUE = 1'b0;
  // Schemes that consult the arbitration table; scheme 0 is fixed round robin
  localparam logic [7:0]  TABLE_SCHEME_MASK = 8'hFE;
  // Table transfer time
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          LOAD_TIME_NS      = 800;
  localparam int          LOAD_CYCLES       = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* src/vrc_table_loader.sv */
// Arbitration table transfer sequencer and coherency flag
`timescale 1ns/100ps
`default_nettype none
module vrc_table_loader
  import vrc_pkg::*;
#(
  parameter int LOAD_LEN = LOAD_CYCLES
)
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic load_start,
  input  wire logic entry_wr,
  output logic      busy,
  output logic      load_done,
  output logic      table_status
);
  localparam int CNT_W = $clog2(LOAD_LEN + 1);

  typedef enum logic [1:0] {
    VRC_IDLE = 2'b01,
    VRC_COPY = 2'b10
  } vrc_load_state_t;

  vrc_load_state_t state;
  vrc_load_state_t next_state;
  logic [CNT_W-1:0] count;
  wire              count_end = (count == CNT_W'(LOAD_LEN - 1));
  wire              finishing = (state == VRC_COPY) && count_end;

  // A zero-length transfer could never finish, so refuse it at elaboration
  if (LOAD_LEN < 1)
  begin : g_len_check
    $error("LOAD_LEN must be at least one cycle");
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      VRC_IDLE: if (load_start) next_state = VRC_COPY;
      VRC_COPY: if (count_end) next_state = VRC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state        <= VRC_IDLE;
      count        <= '0;
      load_done    <= 1'b0;
      table_status <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      count     <= (state == VRC_COPY && !count_end) ? count + 1'b1 : '0;
      load_done <= finishing; // RULE2
      // A write in the completing cycle keeps the flag set
      if (entry_wr)
        table_status <= 1'b1; // RULE8
      else if (finishing)
        table_status <= 1'b0; // RULE8
    end
  end

  assign busy = (state == VRC_COPY);
endmodule
`default_nettype wire

/* src/vrc_ctl_status.sv */
// Channel-0 resource control and status register bank
`timescale 1ns/100ps
`default_nettype none
module vrc_ctl_status
  import vrc_pkg::*;
#(
  parameter int LOAD_LEN = LOAD_CYCLES
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [DATA_W-1:0] cfg_wdata,
  input  wire logic [3:0]        cfg_byte_en,
  input  wire logic [7:0]        port_arb_capability,
  input  wire logic              arb_table_entry_wr,
  output logic [DATA_W-1:0]      cfg_rdata,
  output logic                   cfg_rd_valid,
  output logic                   cfg_unmapped,
  output logic [7:0]             traffic_class_map,
  output logic [2:0]             arb_scheme_select,
  output logic                   arb_table_load_strobe,
  output logic                   arb_load_busy
);
  // A zero-length transfer could never finish, so refuse it at elaboration
  if (LOAD_LEN < 1)
  begin : g_len_check
    $error("LOAD_LEN must be at least one cycle");
  end

  function automatic logic scheme_uses_table(input logic [2:0] sel, input logic [7:0] cap);
    scheme_uses_table = cap[sel] & TABLE_SCHEME_MASK[sel];
  endfunction

  // Address decode
  wire hit_ctl  = (cfg_addr == VC0_CTL_OFFSET);
  wire hit_sts  = (cfg_addr == VC0_STS_OFFSET);
  wire wr_ctl   = cfg_wr && hit_ctl;

  // Only byte lane 0 bits 7:1 of the map are writable
  wire [7:0] next_tc_map = cfg_byte_en[0]
    ? ((cfg_wdata[TC_MAP_LSB +: TC_MAP_W] & TC_MAP_WR_MASK) | (TC_MAP_RESET & ~TC_MAP_WR_MASK))
    : traffic_class_map; // RULE1
  wire [2:0] next_scheme = cfg_byte_en[2] ? cfg_wdata[SCHEME_LSB +: SCHEME_W]
                                          : arb_scheme_select;

  // A zero write is simply not a request; the scheme checked is the one in force
  wire load_req = wr_ctl && cfg_byte_en[2] && cfg_wdata[TABLE_LOAD_BIT]; // RULE3
  wire table_in_use = scheme_uses_table(arb_scheme_select, port_arb_capability); // RULE4 RULE9
  wire load_start = load_req && table_in_use && !arb_load_busy; // RULE4

  wire loader_busy;
  wire loader_done;
  wire table_status;

  vrc_table_loader #(
    .LOAD_LEN (LOAD_LEN)
  ) u_loader (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .load_start   (load_start),
    .entry_wr     (arb_table_entry_wr),
    .busy         (loader_busy),
    .load_done    (loader_done),
    .table_status (table_status)
  );

  // Read images; reserved bits and the load bit are zero
  wire [DATA_W-1:0] ctl_image = {CHAN_EN_VALUE, 4'h0, CHAN_ID_VALUE, 4'h0,
                                 arb_scheme_select, 1'b0, 8'h00,
                                 traffic_class_map}; // RULE12
  // Status flag only matters while the table is in use; the raw flag is shown regardless
  wire [DATA_W-1:0] sts_image = {14'h0, NEG_PENDING_VALUE, table_status,
                                 16'h0000}; // RULE9
  wire [DATA_W-1:0] next_rdata = hit_ctl ? ctl_image :
                                 hit_sts ? sts_image : 32'h0000_0000;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      traffic_class_map <= TC_MAP_RESET; // RULE1
      arb_scheme_select <= SCHEME_RESET;
    end
    else if (wr_ctl)
    begin
      traffic_class_map <= next_tc_map; // RULE1
      arb_scheme_select <= next_scheme;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_rdata    <= 32'h0000_0000;
      cfg_rd_valid <= 1'b0;
      cfg_unmapped <= 1'b0;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd;
      cfg_unmapped <= (cfg_rd || cfg_wr) && !hit_ctl && !hit_sts;
      if (cfg_rd)
        cfg_rdata <= next_rdata; // RULE6 RULE7 RULE10
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      arb_table_load_strobe <= 1'b0;
      arb_load_busy         <= 1'b0;
    end
    else
    begin
      arb_table_load_strobe <= loader_done; // RULE2
      arb_load_busy         <= loader_busy || load_start;
    end
  end
endmodule
`default_nettype wire

/* tb/vrc_ctl_status_assertions.sv */
// Port checks for the channel-0 register bank
`timescale 1ns/100ps
`default_nettype none
module vrc_ctl_status_assertions
  import vrc_pkg::*;
#(parameter int LOAD_LEN = LOAD_CYCLES)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              cfg_wr,
  input wire logic              cfg_rd,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [DATA_W-1:0] cfg_wdata,
  input wire logic [3:0]        cfg_byte_en,
  input wire logic [DATA_W-1:0] cfg_rdata,
  input wire logic              cfg_unmapped,
  input wire logic [7:0]        traffic_class_map,
  input wire logic              arb_table_load_strobe,
  input wire logic              arb_load_busy
);
  // Slack over the transfer length; the exact figure is the loader's
  localparam int LMAX = LOAD_LEN + 4;
  wire logic is_ctl = cfg_addr == VC0_CTL_OFFSET;
  wire logic is_sts = cfg_addr == VC0_STS_OFFSET;
  wire logic ld_req = cfg_wr && is_ctl && cfg_byte_en[2] && cfg_wdata[16];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  map_bit0_a: assert property (traffic_class_map[0])
    else $error("map bit 0 low");
  map_write_a: assert property (cfg_wr && is_ctl && cfg_byte_en[0] |=>
    traffic_class_map == ($past(cfg_wdata[7:0]) | 8'h01)) else $error("map write");
  ctl_map_a: assert property (cfg_rd && is_ctl && !cfg_wr |=>
    cfg_rdata[7:0] == traffic_class_map) else $error("map readback");
  ctl_fixed_a: assert property (cfg_rd && is_ctl |=> cfg_rdata[31] &&
    cfg_rdata[30:20] == 11'h0 && !cfg_rdata[16] && cfg_rdata[15:8] == 8'h00)
    else $error("control fixed bits");
  sts_fixed_a: assert property (cfg_rd && is_sts |=>
    cfg_rdata[31:17] == 15'h0 && cfg_rdata[15:0] == 16'h0000) else $error("status bits");
  unmapped_rd_a: assert property (cfg_rd && !is_ctl && !is_sts |=>
    cfg_unmapped && cfg_rdata == 32'h0) else $error("unmapped read");
  load_cause_a: assert property ($rose(arb_load_busy) |-> $past(ld_req))
    else $error("load without request");
  load_end_a: assert property ($rose(arb_load_busy) |-> ##[1:LMAX] arb_table_load_strobe)
    else $error("load never ends");
  strobe_end_a: assert property (arb_table_load_strobe |->
    !arb_load_busy && $past(arb_load_busy)) else $error("strobe outside load");
endmodule
bind vrc_ctl_status vrc_ctl_status_assertions #(.LOAD_LEN(LOAD_LEN)) u_chk (.ref_clk, .rst,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_byte_en, .cfg_rdata, .cfg_unmapped,
  .traffic_class_map, .arb_table_load_strobe, .arb_load_busy);
`default_nettype wire

/* tb/vrc_ctl_status_tb.sv */
// Self-checking bench for the channel-0 register bank
`timescale 1ns/100ps
`default_nettype none
module vrc_ctl_status_tb
  import vrc_pkg::*;
;
  // Short transfer keeps the run brief
  localparam int LL = 2;
  logic ref_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, arb_table_entry_wr = 1'b0;
  logic [ADDR_W-1:0] cfg_addr = '0;
  logic [DATA_W-1:0] cfg_wdata = '0, cfg_rdata;
  logic [3:0]        cfg_byte_en = 4'h0;
  // Capability covers every scheme the rows select
  logic [7:0]        port_arb_capability = 8'h85, traffic_class_map;
  logic [2:0]        arb_scheme_select;
  logic              cfg_rd_valid, cfg_unmapped, arb_table_load_strobe, arb_load_busy;
  int                fail_count = 0, cmp_count = 0, n;
  // Write data, byte enables, expected control readback
  logic [31:0] rows [5][3] = '{'{32'h0, 32'hF, 32'h80000001},
    '{32'hFFFFFFFE, 32'h1, 32'h800000FF}, '{32'h7FFEFF00, 32'hF, 32'h800E0001},
    '{32'h000400AA, 32'h4, 32'h80040001}, '{32'h000000AA, 32'h1, 32'h800400AB}};
  vrc_ctl_status #(.LOAD_LEN(LL)) u_vrc_ctl_status (.ref_clk, .rst, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .cfg_byte_en, .port_arb_capability, .arb_table_entry_wr,
    .cfg_rdata, .cfg_rd_valid, .cfg_unmapped, .traffic_class_map, .arb_scheme_select,
    .arb_table_load_strobe, .arb_load_busy);
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", s, e, g);
      fail_count++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge ref_clk);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_byte_en} = {1'b1, a, d, b};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    chk("rdata", e, cfg_rdata);
    chk("valid", 32'h1, cfg_rd_valid);
  endtask
  task ent();
    @(negedge ref_clk);
    arb_table_entry_wr = 1'b1;
    @(negedge ref_clk);
    arb_table_entry_wr = 1'b0;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rd(VC0_CTL_OFFSET, 32'h800000FF);
    rd(VC0_STS_OFFSET, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(VC0_CTL_OFFSET, rows[i][0], rows[i][1][3:0]);
      rd(VC0_CTL_OFFSET, rows[i][2]);
      chk("map", rows[i][2] & 32'hFF, traffic_class_map);
      chk("scheme", (rows[i][2] >> 17) & 32'h7, arb_scheme_select);
    end
    $display("rows done");
    port_arb_capability = 8'h05;
    ent();
    wr(VC0_CTL_OFFSET, 32'h00040000, 4'h4);
    chk("busy", 32'h0, arb_load_busy);
    rd(VC0_STS_OFFSET, 32'h00010000);
    wr(VC0_CTL_OFFSET, 32'h00050000, 4'h4);
    chk("busy", 32'h1, arb_load_busy);
    n = 0;
    while (arb_table_load_strobe !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("strobe", 32'h1, arb_table_load_strobe);
    rd(VC0_STS_OFFSET, 32'h0);
    $display("load done");
    ent();
    // The load is judged against the scheme already in force, so select it first
    wr(VC0_CTL_OFFSET, 32'h00000000, 4'h4);
    wr(VC0_CTL_OFFSET, 32'h00010000, 4'h4);
    chk("busy", 32'h0, arb_load_busy);
    rd(VC0_STS_OFFSET, 32'h00010000);
    rd(12'h21C, 32'h0);
    chk("unmapped", 32'h1, cfg_unmapped);
    $display("refused done");
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rd(VC0_CTL_OFFSET, 32'h800000FF);
    rd(VC0_STS_OFFSET, 32'h0);
    $display("reset done");
    summarize();
  end
endmodule
`default_nettype wire
